/* File: src/float_control_spill_trap.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Block fraction carry into characteristic on float.
// - Suppress forced one at adder P on float.
// - Tally rests one, steps two at divide.
// - Tally returns to one at divide end.
// - Seven control triggers, all off when idle.
// - Trigger 1 aligns, trigger 2 adds.
// - Trigger 3 complements or adds one.
// - Trigger 4 normalizes and adjusts characteristic.
// - Trigger 5 shifts overflow, extension characteristic, ends.
// - Trigger 6 complements extension fraction when needed.
// - Trigger 7 restores corrected extension data.
// - Triggers 1 to 4 skipped on single add early end.
// - Double sync zero enables single gating.
// - Detect overflow and underflow per register.
// - Reset and enter set trap mode; leave clears.
// - Trap only while trap mode set.
// - Write location plus one and code to word zero.
// - Spill code uses bits fourteen to seventeen.
// - Extension characteristic P sets extension overflow.
// - Fetch cycle main P sets trap trigger.
// - Extension overflow also sets trap; trap starts.
// - Bit fourteen divide trigger, bit sixteen main P.
// - Characteristic is exponent biased by two hundred octal.
module float_control_spill_trap
(
	input wire logic CLOCK_I,
	input wire logic NRST_I,
	input wire logic CLK_EN_I,
	input wire float_trap_pkg::decode_t DECODE_I,
	input wire logic FIXED_ONE_REQ_I,
	input wire logic LATE_CYCLE_SEVENTH_PULSE_I,
	input wire logic END_CYCLE_FIRST_PULSE_I,
	input wire logic OP_END_I,
	input wire logic EXEC_DONE_I,
	input wire logic EARLY_END_I,
	input wire logic [7:0] SHIFT_COUNT_I,
	input wire logic SIGNS_UNLIKE_I,
	input wire logic FRACTION_CARRY_I,
	input wire logic PRE_END_OP_I,
	input wire logic FRACTION_NORMALIZED_I,
	input wire logic SR_GT_AC_I,
	input wire logic EXT_SIGNIFICANT_I,
	input wire logic DPS_STEP_I,
	input wire logic EXT_CHAR_STROBE_I,
	input wire logic [9:0] ADDER_CHAR_I,
	input wire logic FETCH_AFTER_FLOAT_I,
	input wire logic [9:0] MAIN_CHAR_I,
	input wire logic [9:0] EXT_CHAR_I,
	input wire logic [14:0] INSTR_LOC_I,
	input wire logic TRAP_ACK_I,
	output logic CARRY_9_TO_8_EN_O,
	output logic FORCE_ONE_9P_O,
	output logic TALLY_TWO_O,
	output logic [6:0] FACT_O,
	output logic FACT3_ADD_ONE_O,
	output logic FRACTION_SHIFT_RIGHT_O,
	output logic OP_DONE_O,
	output logic [1:0] DPS_O,
	output logic SINGLE_GATE_O,
	output logic MAIN_OVERFLOW_O,
	output logic MAIN_UNDERFLOW_O,
	output logic EXT_OVERFLOW_O,
	output logic EXT_UNDERFLOW_O,
	output logic [7:0] MAIN_EXPONENT_O,
	output logic TRAP_MODE_O,
	output logic TRAP_START_O,
	output logic MEM0_WRITE_O,
	output logic [35:0] MEM0_WORD_O,
	input wire logic [3:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [3:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and shared state.

	logic rst_meta_n_reg; // First reset release stage, read only by the second.
	logic rst_n_reg; // Synchronised reset used by all other logic.
	float_trap_pkg::fact_state_t fact_reg; // Current control trigger.
	float_trap_pkg::fact_state_t fact_next; // Next control trigger.
	logic tally_two_reg; // High when the tally counter holds two.
	logic carry_unlike_reg; // Fraction carry seen on an unlike-sign add.
	logic carry_trig_reg; // Fraction carry to be shifted back in trigger 5.
	logic [1:0] dps_reg; // Double-precision sync stage.
	logic trap_mode_reg; // Floating-trap mode trigger.
	logic ext_ovf_reg; // Extension overflow trigger 1.
	logic fp_ovf_reg; // Floating overflow trigger 1.
	logic divide_trig_reg; // Single-precision divide trigger.
	logic main_p_reg; // Main result P seen in the fetch cycle.
	logic trap_trig_reg; // Floating trap trigger.
	logic op_done_reg; // One-cycle pulse at the end of a trigger sequence.
	logic trap_start_reg; // One-cycle pulse when the trap sequence starts.
	logic [35:0] mem0_word_reg; // Word written to location zero.
	logic fetch_p; // Main result P in the fetch cycle.
	logic fetch_trap; // Trap trigger condition in the fetch cycle.
	logic enter_cmd; // Software or instruction entry into trap mode.
	logic leave_cmd; // Software or instruction exit from trap mode.
	logic ack_cmd; // Input or software acknowledge of a finished trap.

	// The reset is asserted at once and released through two flip-flops.
	always_ff @(posedge CLOCK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			rst_meta_n_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_n_reg <= 1'b1;
			rst_n_reg <= rst_meta_n_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Adder separation.

	// On any float instruction the fraction carry stops short of the characteristic.
	assign CARRY_9_TO_8_EN_O = ~DECODE_I.float_instr;
	// The forced one at the P position belongs to fixed-point work only.
	assign FORCE_ONE_9P_O = FIXED_ONE_REQ_I & ~DECODE_I.float_instr;

	////////////////////////////////////////////////////////////////////////////////
	// Tally counter.

	// The counter rests at one, steps to two after the first late cycle of a divide.
	always_ff @(posedge CLOCK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			tally_two_reg <= 1'b0;
		else if (CLK_EN_I)
		begin
			// Ending the divide wins over a step in the same cycle.
			if (END_CYCLE_FIRST_PULSE_I && OP_END_I)
				tally_two_reg <= 1'b0;
			else if (LATE_CYCLE_SEVENTH_PULSE_I && !tally_two_reg &&
				(DECODE_I.single_divide || DECODE_I.double_divide))
				tally_two_reg <= 1'b1;
		end
	end

	assign TALLY_TWO_O = tally_two_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Floating-add control triggers.

	// Chooses the next trigger from the current one and the datapath conditions.
	always_comb
	begin
		fact_next = fact_reg;
		case (fact_reg)
			float_trap_pkg::FACT_IDLE:
			begin
				// The execute cycle decides which trigger starts, if any.
				if (EXEC_DONE_I)
				begin
					if (DECODE_I.single_add_sub && EARLY_END_I)
						fact_next = float_trap_pkg::FACT_5;
					else if ((DECODE_I.single_add_sub || DECODE_I.double_add_sub) && SHIFT_COUNT_I != 8'h00)
						fact_next = float_trap_pkg::FACT_1;
					else if ((DECODE_I.single_add_sub || DECODE_I.double_add_sub || DECODE_I.double_divide)
						&& !EARLY_END_I)
						fact_next = float_trap_pkg::FACT_2;
					else if ((DECODE_I.single_multiply || DECODE_I.double_multiply) && !EARLY_END_I)
						fact_next = float_trap_pkg::FACT_5;
				end
			end
			float_trap_pkg::FACT_1:
			begin
				// Alignment ends once two or fewer places remain to shift.
				if (SHIFT_COUNT_I <= 8'h02)
					fact_next = float_trap_pkg::FACT_2;
			end
			float_trap_pkg::FACT_2:
			begin
				// Unlike signs need a recomplement or end-around one.
				if (SIGNS_UNLIKE_I)
					fact_next = float_trap_pkg::FACT_3;
				else if (DECODE_I.normal_instr && !FRACTION_CARRY_I && !PRE_END_OP_I)
					fact_next = float_trap_pkg::FACT_4;
				else
					fact_next = float_trap_pkg::FACT_5;
			end
			float_trap_pkg::FACT_3:
			begin
				// Normal instructions go on to normalize.
				if (DECODE_I.normal_instr)
					fact_next = float_trap_pkg::FACT_4;
				else
					fact_next = float_trap_pkg::FACT_5;
			end
			float_trap_pkg::FACT_4:
			begin
				// Left shifting stops when the high fraction bit is one.
				if (FRACTION_NORMALIZED_I)
					fact_next = float_trap_pkg::FACT_5;
			end
			float_trap_pkg::FACT_5:
			begin
				// The extension fraction may still need a recomplement.
				if (SIGNS_UNLIKE_I && SR_GT_AC_I && EXT_SIGNIFICANT_I)
					fact_next = float_trap_pkg::FACT_6;
				else
					fact_next = float_trap_pkg::FACT_IDLE;
			end
			float_trap_pkg::FACT_6:
				fact_next = float_trap_pkg::FACT_7;
			float_trap_pkg::FACT_7:
				fact_next = float_trap_pkg::FACT_IDLE;
			default:
				fact_next = float_trap_pkg::FACT_IDLE;
		endcase
	end

	// Holds the active trigger; all triggers are off after reset.
	always_ff @(posedge CLOCK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			fact_reg <= float_trap_pkg::FACT_IDLE;
		else if (CLK_EN_I)
			fact_reg <= fact_next;
	end

	// Remembers carries from the addition for triggers 3 and 5.
	always_ff @(posedge CLOCK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			carry_unlike_reg <= 1'b0;
			carry_trig_reg <= 1'b0;
		end
		else if (CLK_EN_I)
		begin
			if (fact_reg == float_trap_pkg::FACT_2)
			begin
				carry_unlike_reg <= FRACTION_CARRY_I & SIGNS_UNLIKE_I;
				carry_trig_reg <= FRACTION_CARRY_I & ~SIGNS_UNLIKE_I;
			end
			else if (fact_reg == float_trap_pkg::FACT_IDLE)
			begin
				carry_unlike_reg <= 1'b0;
				carry_trig_reg <= 1'b0;
			end
		end
	end

	// Marks the cycle after a trigger sequence has finished.
	always_ff @(posedge CLOCK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			op_done_reg <= 1'b0;
		else if (CLK_EN_I)
			op_done_reg <= (fact_reg != float_trap_pkg::FACT_IDLE) && (fact_next == float_trap_pkg::FACT_IDLE);
	end

	// One bit per trigger, bit 0 being trigger 1.
	always_comb
	begin
		FACT_O = '0;
		if (fact_reg != float_trap_pkg::FACT_IDLE)
			FACT_O[fact_reg - 3'h1] = 1'b1;
	end

	assign FACT3_ADD_ONE_O = carry_unlike_reg;
	assign FRACTION_SHIFT_RIGHT_O = (fact_reg == float_trap_pkg::FACT_5) & carry_trig_reg;
	assign OP_DONE_O = op_done_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Double-precision sync.

	// Steps through its four stages and returns to zero at operation end.
	always_ff @(posedge CLOCK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			dps_reg <= '0;
		else if (CLK_EN_I)
		begin
			if (OP_END_I)
				dps_reg <= '0;
			else if (DPS_STEP_I)
				dps_reg <= dps_reg + 2'h1;
		end
	end

	assign DPS_O = dps_reg;
	assign SINGLE_GATE_O = (dps_reg == '0);

	////////////////////////////////////////////////////////////////////////////////
	// Characteristic checks.

	// Q and P above the biased characteristic show the spill and its direction.
	assign MAIN_OVERFLOW_O = MAIN_CHAR_I[float_trap_pkg::CHAR_P_BIT] & ~MAIN_CHAR_I[float_trap_pkg::CHAR_Q_BIT];
	assign MAIN_UNDERFLOW_O = MAIN_CHAR_I[float_trap_pkg::CHAR_P_BIT] & MAIN_CHAR_I[float_trap_pkg::CHAR_Q_BIT];
	assign EXT_OVERFLOW_O = EXT_CHAR_I[float_trap_pkg::CHAR_P_BIT] & ~EXT_CHAR_I[float_trap_pkg::CHAR_Q_BIT];
	assign EXT_UNDERFLOW_O = EXT_CHAR_I[float_trap_pkg::CHAR_P_BIT] & EXT_CHAR_I[float_trap_pkg::CHAR_Q_BIT];
	// The exponent is the characteristic less the bias, in two's complement.
	assign MAIN_EXPONENT_O = MAIN_CHAR_I[float_trap_pkg::CHAR_W-1:0] - float_trap_pkg::EXP_BIAS;

	////////////////////////////////////////////////////////////////////////////////
	// Trap mode and spill triggers.

	logic wr_ctrl; // Accepted write to the control register.
	logic [31:0] wdata_reg; // Held write data.
	logic [3:0] wstrb_reg; // Held write strobes.

	assign enter_cmd = DECODE_I.enter_trap_mode_instr | (wr_ctrl & wstrb_reg[0] & wdata_reg[float_trap_pkg::CTRL_ENTER_BIT]);
	assign leave_cmd = DECODE_I.leave_trap_mode_instr | (wr_ctrl & wstrb_reg[0] & wdata_reg[float_trap_pkg::CTRL_LEAVE_BIT]);
	assign ack_cmd = TRAP_ACK_I | (wr_ctrl & wstrb_reg[0] & wdata_reg[float_trap_pkg::CTRL_ACK_BIT]);

	// Trap mode is on from reset; entry wins if both commands coincide.
	always_ff @(posedge CLOCK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			trap_mode_reg <= 1'b1;
		else if (CLK_EN_I)
		begin
			if (enter_cmd)
				trap_mode_reg <= 1'b1;
			else if (leave_cmd)
				trap_mode_reg <= 1'b0;
		end
	end

	assign TRAP_MODE_O = trap_mode_reg;
	assign fetch_p = FETCH_AFTER_FLOAT_I & MAIN_CHAR_I[float_trap_pkg::CHAR_P_BIT];
	assign fetch_trap = FETCH_AFTER_FLOAT_I & (MAIN_CHAR_I[float_trap_pkg::CHAR_P_BIT] | ext_ovf_reg);

	// Spill triggers set on their events; a set in the acknowledge cycle wins.
	always_ff @(posedge CLOCK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			ext_ovf_reg <= 1'b0;
			fp_ovf_reg <= 1'b0;
			divide_trig_reg <= 1'b0;
			main_p_reg <= 1'b0;
		end
		else if (CLK_EN_I)
		begin
			// Extension characteristic leaving the adder.
			if (EXT_CHAR_STROBE_I && ADDER_CHAR_I[float_trap_pkg::CHAR_P_BIT])
				ext_ovf_reg <= 1'b1;
			else if (ack_cmd || (FETCH_AFTER_FLOAT_I && !trap_mode_reg))
				ext_ovf_reg <= 1'b0;
			// Overflow from either register.
			if ((EXT_CHAR_STROBE_I && ADDER_CHAR_I[float_trap_pkg::CHAR_P_BIT] &&
				!ADDER_CHAR_I[float_trap_pkg::CHAR_Q_BIT]) ||
				(fetch_p && trap_mode_reg && !MAIN_CHAR_I[float_trap_pkg::CHAR_Q_BIT]))
				fp_ovf_reg <= 1'b1;
			else if (ack_cmd || (FETCH_AFTER_FLOAT_I && !trap_mode_reg))
				fp_ovf_reg <= 1'b0;
			// Every single-precision divide sets the divide trigger.
			if (DECODE_I.single_divide)
				divide_trig_reg <= 1'b1;
			else if (ack_cmd || (FETCH_AFTER_FLOAT_I && !trap_mode_reg) || (FETCH_AFTER_FLOAT_I && !fetch_trap))
				divide_trig_reg <= 1'b0;
			// Main result P as seen in the fetch cycle.
			if (fetch_p)
				main_p_reg <= 1'b1;
			else if (ack_cmd)
				main_p_reg <= 1'b0;
		end
	end

	// The trap trigger and the word for location zero, only in trap mode.
	always_ff @(posedge CLOCK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			trap_trig_reg <= 1'b0;
			trap_start_reg <= 1'b0;
			mem0_word_reg <= '0;
		end
		else if (CLK_EN_I)
		begin
			trap_start_reg <= 1'b0;
			if (fetch_trap && trap_mode_reg)
			begin
				trap_trig_reg <= 1'b1;
				trap_start_reg <= 1'b1;
				mem0_word_reg <= '0;
				mem0_word_reg[float_trap_pkg::LOC_W-1:0] <= INSTR_LOC_I + float_trap_pkg::LOC_ONE;
				mem0_word_reg[float_trap_pkg::SPILL_BIT14] <= divide_trig_reg | DECODE_I.single_divide;
				mem0_word_reg[float_trap_pkg::SPILL_BIT15] <= fp_ovf_reg |
					(MAIN_CHAR_I[float_trap_pkg::CHAR_P_BIT] & ~MAIN_CHAR_I[float_trap_pkg::CHAR_Q_BIT]);
				mem0_word_reg[float_trap_pkg::SPILL_BIT16] <= MAIN_CHAR_I[float_trap_pkg::CHAR_P_BIT];
				mem0_word_reg[float_trap_pkg::SPILL_BIT17] <= ext_ovf_reg;
			end
			else if (ack_cmd)
				trap_trig_reg <= 1'b0;
		end
	end

	assign TRAP_START_O = trap_start_reg;
	assign MEM0_WRITE_O = trap_start_reg;
	assign MEM0_WORD_O = mem0_word_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus slave.

	logic aw_held_reg; // Write address taken and waiting.
	logic w_held_reg; // Write data taken and waiting.
	logic [3:0] awaddr_reg; // Held write address.
	logic bvalid_reg; // Write response pending.
	logic [1:0] bresp_reg; // Write response code.
	logic rvalid_reg; // Read data pending.
	logic [31:0] rdata_reg; // Read data.
	logic [1:0] rresp_reg; // Read response code.
	logic [31:0] status_word; // Live block state.

	assign S_AXI_AWREADY_O = ~aw_held_reg & ~bvalid_reg;
	assign S_AXI_WREADY_O = ~w_held_reg & ~bvalid_reg;
	assign wr_ctrl = CLK_EN_I & aw_held_reg & w_held_reg & (awaddr_reg == float_trap_pkg::CTRL_OFFSET);

	// Takes address and data in either order and answers once both are held.
	always_ff @(posedge CLOCK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= float_trap_pkg::RESP_OKAY;
		end
		else if (CLK_EN_I)
		begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O)
			begin
				w_held_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA_I;
				wstrb_reg <= S_AXI_WSTRB_I;
			end
			if (aw_held_reg && w_held_reg)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				// Only the control register is writable.
				bresp_reg <= (awaddr_reg == float_trap_pkg::CTRL_OFFSET) ?
					float_trap_pkg::RESP_OKAY : float_trap_pkg::RESP_SLVERR;
			end
			else if (bvalid_reg && S_AXI_BREADY_I)
				bvalid_reg <= 1'b0;
		end
	end

	// Gathers the block state for software.
	always_comb
	begin
		status_word = '0;
		status_word[float_trap_pkg::ST_TRAP_MODE_BIT] = trap_mode_reg;
		status_word[float_trap_pkg::ST_TRAP_TRIG_BIT] = trap_trig_reg;
		status_word[float_trap_pkg::ST_TALLY_TWO_BIT] = tally_two_reg;
		status_word[float_trap_pkg::ST_EXT_OVF_BIT] = ext_ovf_reg;
		status_word[float_trap_pkg::ST_FP_OVF_BIT] = fp_ovf_reg;
		status_word[float_trap_pkg::ST_DIVIDE_BIT] = divide_trig_reg;
		status_word[float_trap_pkg::ST_DPS_LSB +: float_trap_pkg::DPS_W] = dps_reg;
		status_word[float_trap_pkg::ST_FACT_LSB +: float_trap_pkg::FACT_N] = FACT_O;
	end

	assign S_AXI_ARREADY_O = ~rvalid_reg;

	// Answers a read one cycle after the address is taken.
	always_ff @(posedge CLOCK_I or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= float_trap_pkg::RESP_OKAY;
		end
		else if (CLK_EN_I)
		begin
			if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
			begin
				rvalid_reg <= 1'b1;
				rresp_reg <= float_trap_pkg::RESP_OKAY;
				case (S_AXI_ARADDR_I)
					float_trap_pkg::CTRL_OFFSET:
						rdata_reg <= '0;
					float_trap_pkg::STATUS_OFFSET:
						rdata_reg <= status_word;
					float_trap_pkg::SPILL_LO_OFFSET:
						rdata_reg <= mem0_word_reg[31:0];
					float_trap_pkg::SPILL_HI_OFFSET:
						rdata_reg <= {28'h0000000, mem0_word_reg[35:32]};
					default:
					begin
						rdata_reg <= '0;
						rresp_reg <= float_trap_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (rvalid_reg && S_AXI_RREADY_I)
				rvalid_reg <= 1'b0;
		end
	end

	assign S_AXI_BVALID_O = bvalid_reg;
	assign S_AXI_BRESP_O = bresp_reg;
	assign S_AXI_RVALID_O = rvalid_reg;
	assign S_AXI_RDATA_O = rdata_reg;
	assign S_AXI_RRESP_O = rresp_reg;

endmodule

/* File: inc/float_trap_pkg.sv */
// Shared constants and types for the floating-point control and spill trap block.
package float_trap_pkg;

	// Register bus geometry.
	localparam int AXI_ADDR_W = 4;
	localparam int AXI_DATA_W = 32;

	// Register byte offsets.
	localparam logic [AXI_ADDR_W-1:0] CTRL_OFFSET = 4'h0;
	localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 4'h4;
	localparam logic [AXI_ADDR_W-1:0] SPILL_LO_OFFSET = 4'h8;
	localparam logic [AXI_ADDR_W-1:0] SPILL_HI_OFFSET = 4'hc;

	// Control register command bits, self clearing on write.
	localparam int CTRL_ENTER_BIT = 0;
	localparam int CTRL_LEAVE_BIT = 1;
	localparam int CTRL_ACK_BIT = 2;

	// Status register field positions.
	localparam int ST_TRAP_MODE_BIT = 0;
	localparam int ST_TRAP_TRIG_BIT = 1;
	localparam int ST_TALLY_TWO_BIT = 2;
	localparam int ST_EXT_OVF_BIT = 3;
	localparam int ST_FP_OVF_BIT = 4;
	localparam int ST_DIVIDE_BIT = 5;
	localparam int ST_DPS_LSB = 8;
	localparam int ST_FACT_LSB = 16;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Characteristic layout: Q and P above eight characteristic bits.
	localparam int CHAR_W = 8;
	localparam int CHAR_P_BIT = 8;
	localparam int CHAR_Q_BIT = 9;
	localparam logic [CHAR_W-1:0] EXP_BIAS = 8'h80;

	// Machine word, bit 0 is the sign at the high end of the vector.
	localparam int WORD_W = 36;
	localparam int LOC_W = 15;
	localparam int SPILL_BIT14 = WORD_W - 1 - 14;
	localparam int SPILL_BIT15 = WORD_W - 1 - 15;
	localparam int SPILL_BIT16 = WORD_W - 1 - 16;
	localparam int SPILL_BIT17 = WORD_W - 1 - 17;
	localparam logic [LOC_W-1:0] LOC_ONE = 15'h0001;
	localparam int DPS_W = 2;
	localparam int FACT_N = 7;

	// Instruction decode delivered by the sequencer.
	typedef struct packed {
		logic float_instr;
		logic single_add_sub;
		logic double_add_sub;
		logic single_multiply;
		logic double_multiply;
		logic single_divide;
		logic double_divide;
		logic normal_instr;
		logic leave_trap_mode_instr;
		logic enter_trap_mode_instr;
	} decode_t;

	// Floating-add control trigger sequence.
	typedef enum logic [2:0] {
		FACT_IDLE,
		FACT_1,
		FACT_2,
		FACT_3,
		FACT_4,
		FACT_5,
		FACT_6,
		FACT_7
	} fact_state_t;

endpackage

/* File: bench/float_trap_monitor.sv */
`timescale 1ns/1ps
// Port checks on adder separation, sync gating, flags and trap entry.
module float_trap_monitor
(
	input wire logic CLOCK_I,
	input wire logic NRST_I,
	input wire float_trap_pkg::decode_t DECODE_I,
	input wire logic FETCH_AFTER_FLOAT_I,
	input wire logic [9:0] MAIN_CHAR_I,
	input wire logic CARRY_9_TO_8_EN_O,
	input wire logic FORCE_ONE_9P_O,
	input wire logic [6:0] FACT_O,
	input wire logic [1:0] DPS_O,
	input wire logic SINGLE_GATE_O,
	input wire logic MAIN_OVERFLOW_O,
	input wire logic TRAP_MODE_O,
	input wire logic TRAP_START_O,
	input wire logic MEM0_WRITE_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!NRST_I);
	property p_carry; CARRY_9_TO_8_EN_O == !DECODE_I.float_instr; endproperty
	a_carry: assert property (p_carry) else $error("fraction carry not blocked");
	property p_force; DECODE_I.float_instr |-> !FORCE_ONE_9P_O; endproperty
	a_force: assert property (p_force) else $error("forced one on float");
	property p_gate; SINGLE_GATE_O == (DPS_O == 2'h0); endproperty
	a_gate: assert property (p_gate) else $error("single gate wrong");
	property p_fact; $onehot0(FACT_O); endproperty
	a_fact: assert property (p_fact) else $error("two triggers on");
	property p_ovf; MAIN_OVERFLOW_O == (MAIN_CHAR_I[8] && !MAIN_CHAR_I[9]); endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
	property p_trap; FETCH_AFTER_FLOAT_I && TRAP_MODE_O && MAIN_CHAR_I[8] |=> MEM0_WRITE_O ##1 !TRAP_START_O; endproperty
	a_trap: assert property (p_trap) else $error("spill not trapped");
	property p_off; FETCH_AFTER_FLOAT_I && !TRAP_MODE_O |=> !MEM0_WRITE_O; endproperty
	a_off: assert property (p_off) else $error("write with mode off");
	property p_only; TRAP_START_O |-> $past(TRAP_MODE_O) && MEM0_WRITE_O; endproperty
	a_only: assert property (p_only) else $error("trap outside mode");
	c_trap: cover property (TRAP_START_O);
	c_off: cover property (FETCH_AFTER_FLOAT_I && !TRAP_MODE_O);
	c_float: cover property (DECODE_I.float_instr);
	c_fact: cover property (FACT_O[6]);
endmodule

/* File: bench/float_seq_model.sv */
`timescale 1ns/1ps
// Stand-in for the sequencer and datapath feeding the block.
module float_seq_model
(
	input wire logic clk_i,
	output float_trap_pkg::decode_t dec_o,
	output logic fetch_o,
	output logic stb_o,
	output logic l7_o,
	output logic a1_o,
	output logic [9:0] ch_o,
	output logic [14:0] loc_o
);
	// Idle levels at time zero.
	initial
	begin
		dec_o = '0;
		{fetch_o, stb_o, l7_o, a1_o} = 4'h0;
		ch_o = 10'h000;
		loc_o = 15'h0100;
	end
	// One-cycle strobe with a characteristic, which goes stale after it.
	task automatic op(input logic ext, input logic [9:0] c);
		@(posedge clk_i);
		fetch_o <= !ext;
		stb_o <= ext;
		ch_o <= c;
		@(posedge clk_i);
		{fetch_o, stb_o} <= 2'h0;
		ch_o <= ~c;
	endtask
	// Holds a decoded instruction from the next edge on.
	task automatic dec_set(input float_trap_pkg::decode_t d);
		@(posedge clk_i);
		dec_o <= d;
	endtask
	// Decoded enter-trap-mode instruction for one cycle.
	task automatic enter_op();
		@(posedge clk_i);
		dec_o.enter_trap_mode_instr <= 1'b1;
		@(posedge clk_i);
		dec_o <= '0;
	endtask
	// Divide decode with the late pulse, or with the end pulse and a cleared decode when fin is set.
	task automatic div_op(input logic fin);
		@(posedge clk_i);
		dec_o.float_instr <= 1'b1;
		dec_o.single_divide <= 1'b1;
		{l7_o, a1_o} <= {!fin, fin};
		@(posedge clk_i);
		{l7_o, a1_o} <= 2'h0;
		if (fin)
			dec_o <= '0;
	endtask
endmodule

/* File: bench/float_control_spill_trap_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module float_control_spill_trap_tb_top;
	logic clk, nrst, awv, wv, bre, arv, rre, fet, stb, l7, a1, awr, wrd, bv, arr, rv, tal, mode, st, mw, gate;
	logic [3:0] aw, ar;
	logic [31:0] wd, rdat;
	logic [1:0] br, rr;
	logic [9:0] ch;
	logic [16:0] dp; // Datapath levels and pulses for the trigger sequence.
	logic [6:0] fact;
	logic [14:0] loc;
	logic [35:0] word;
	float_trap_pkg::decode_t dec;
	int checks, mismatches;
	localparam logic [1:0] OK = float_trap_pkg::RESP_OKAY;
	float_seq_model seq(.clk_i(clk), .dec_o(dec), .fetch_o(fet), .stb_o(stb), .l7_o(l7), .a1_o(a1), .ch_o(ch), .loc_o(loc));
	float_control_spill_trap dut(.CLOCK_I(clk), .NRST_I(nrst), .CLK_EN_I(1'b1), .DECODE_I(dec), .FIXED_ONE_REQ_I(1'b1),
		.LATE_CYCLE_SEVENTH_PULSE_I(l7), .END_CYCLE_FIRST_PULSE_I(a1), .OP_END_I(a1), .EXEC_DONE_I(dp[0]),
		.EARLY_END_I(dp[1]), .SHIFT_COUNT_I(dp[9:2]), .SIGNS_UNLIKE_I(dp[10]), .FRACTION_CARRY_I(dp[11]),
		.PRE_END_OP_I(dp[12]), .FRACTION_NORMALIZED_I(dp[13]), .SR_GT_AC_I(dp[14]), .EXT_SIGNIFICANT_I(dp[15]),
		.DPS_STEP_I(dp[16]),
		.EXT_CHAR_STROBE_I(stb), .ADDER_CHAR_I(ch), .FETCH_AFTER_FLOAT_I(fet), .MAIN_CHAR_I(ch), .EXT_CHAR_I(ch),
		.INSTR_LOC_I(loc), .TRAP_ACK_I(1'b0), .CARRY_9_TO_8_EN_O(), .FORCE_ONE_9P_O(), .TALLY_TWO_O(tal), .FACT_O(fact),
		.FACT3_ADD_ONE_O(), .FRACTION_SHIFT_RIGHT_O(), .OP_DONE_O(), .DPS_O(), .SINGLE_GATE_O(gate),
		.MAIN_OVERFLOW_O(), .MAIN_UNDERFLOW_O(), .EXT_OVERFLOW_O(), .EXT_UNDERFLOW_O(), .MAIN_EXPONENT_O(),
		.TRAP_MODE_O(mode), .TRAP_START_O(st), .MEM0_WRITE_O(mw), .MEM0_WORD_O(word), .S_AXI_AWADDR_I(aw),
		.S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ar),
		.S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rre));
	// Register write; each channel is dropped once taken, then the response is checked.
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge clk);
		{aw, wd, awv, wv, bre} <= {a, d, 3'h7};
		do begin @(posedge clk); if (awv && awr) awv <= 1'b0; if (wv && wrd) wv <= 1'b0; end while (bv !== 1'b1);
		bre <= 1'b0;
		`CHK(br, e)
	endtask
	// Register read with expected data and response.
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge clk);
		{ar, arv, rre} <= {a, 2'h3};
		do begin @(posedge clk); if (arv && arr) arv <= 1'b0; end while (rv !== 1'b1);
		rre <= 1'b0;
		`CHK(rdat, d)
		`CHK(rr, e)
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Cuts a hang short after far more cycles than the tests need.
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		test_done();
	end
	initial
	begin
		{nrst, awv, wv, bre, arv, rre, aw, ar, wd, dp} = '0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK({mode, gate}, 2'h3)
		rd(4'h4, 32'h1, OK);
		wr(4'h4, 32'h0, float_trap_pkg::RESP_SLVERR);
		seq.op(1'b0, 10'h100);
		#1 `CHK({st, mw, word}, {2'h3, 36'h000180101})
		rd(4'h4, 32'h13, OK);
		rd(4'h8, 32'h00180101, OK);
		rd(4'hc, 32'h0, OK);
		wr(4'h0, 32'h4, OK);
		wr(4'h0, 32'h2, OK);
		`CHK(mode, 1'b0)
		seq.op(1'b0, 10'h100);
		#1 `CHK({st, mw}, 2'h0)
		seq.enter_op();
		#1 `CHK(mode, 1'b1)
		seq.op(1'b1, 10'h300);
		seq.op(1'b0, 10'h080);
		#1 `CHK({st, word}, {1'b1, 36'h000040101})
		// A normal single add walks triggers one to seven; the sync step drops the single gate.
		seq.dec_set(10'h304);
		dp <= 17'h1ec05;
		@(posedge clk);
		dp <= 17'h0ec04;
		for (int i = 0; i < 8; i++)
		begin
			#1 `CHK({fact, gate}, {(i < 7) ? 7'h01 << i : 7'h00, 1'b0})
			@(posedge clk);
		end
		seq.div_op(1'b0);
		#1 `CHK(tal, 1'b1)
		seq.div_op(1'b1);
		#1 `CHK({tal, gate}, 2'h1)
		test_done();
	end
endmodule
bind float_control_spill_trap float_trap_monitor mon(.*);
